/* core/tenbase_t_ctrl_regs.vh */
// Register offsets, field positions, reset values and gap timing
// for the 10 Mb/s control and self-test extension registers.
`ifndef TENBASE_T_CTRL_REGS_VH
`define TENBASE_T_CTRL_REGS_VH

`define TBT_SC_ADDR 5'h1a
`define TBT_EXT_ADDR 5'h1b

`define TBT_SC_RESET 16'h0804
`define TBT_SC_SQUELCH_HI 11
`define TBT_SC_SQUELCH_LO 9
`define TBT_SC_ECHO_DIS 8
`define TBT_SC_LINK_PULSE_TX_DISABLE 7
`define TBT_SC_FORCE_LINK 6
`define TBT_SC_POLARITY 4
`define TBT_SC_COLL_TEST_DIS 1
`define TBT_SC_GUARD_DIS 0
`define TBT_SC_WMASK 16'hffef

`define TBT_EXT_RESET 16'h0000
`define TBT_EXT_ERR_HI 15
`define TBT_EXT_ERR_LO 8
`define TBT_EXT_CONT 5
`define TBT_EXT_PAT_EN 4
`define TBT_EXT_GAP_SEL 2
`define TBT_EXT_PAT_HI 1
`define TBT_EXT_PAT_LO 0
`define TBT_EXT_WMASK 16'h00ff

`define TBT_CLK_MHZ 125
`define TBT_GAP_SHORT_US 10
`define TBT_GAP_LONG_US 15
`define TBT_GAP_SHORT_CYC (`TBT_GAP_SHORT_US * `TBT_CLK_MHZ)
`define TBT_GAP_LONG_CYC (`TBT_GAP_LONG_US * `TBT_CLK_MHZ)

`endif

/* core/tenbase_t_control_and_bist_ext.v */
// 10 Mb/s status/control and self-test/driver test extension registers.
// Assumes a management front end giving one-cycle read/write strobes on i_core_clk,
// and datapath, link and self-test status signals from the same clock domain.
// Read data is combinational so the front end can take it in the strobe cycle.
// Reserved bits are stored as written; the polarity bit is never stored.
// No synchronisers: every input is already on i_core_clk.
//
// Operation
// - Squelch field bits 11:9, reset 100
// - Half-duplex echo unless echo disable set
// - Basic-mode loopback ignores echo disable
// - Bit 7 stops normal link pulses
// - Bit 6 forces good 10 Mb/s link
// - Heartbeat disable only half-duplex 10 Mb/s
// - Bit 0 disables jabber, 10 Mb/s only
// - Bits 15:8 read-only self-test error count
// - Counter clears on restart, saturates
// - Continuous mode sends unbroken pseudo-random data
// - Pattern enable drives selected test pattern
// - Gap select: 15 us or 10 us
// - Select field picks one of four patterns
// - Force-error pulse adds one error count a cycle later, merged with a nibble error in that later cycle
`timescale 1ns/1ps
`include "tenbase_t_ctrl_regs.vh"

module tenbase_t_control_and_bist_ext #(
    parameter GAP_SHORT_CYC = `TBT_GAP_SHORT_CYC,
    parameter GAP_LONG_CYC = `TBT_GAP_LONG_CYC
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst_n,
    // Management register access
    input wire [4:0] i_reg_addr,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [15:0] i_reg_wdata,
    output reg [15:0] o_reg_rdata,
    output wire o_reg_hit,
    // Operating mode
    input wire i_speed_10,
    input wire i_full_duplex,
    input wire i_basic_loopback,
    // Status inputs
    input wire i_pol_inverted_evt,
    input wire i_phy_status_rd,
    input wire i_link_pulse_good,
    input wire i_selftest_start,
    input wire i_selftest_nibble_err,
    input wire i_selftest_inject_error,
    // Transmit datapath
    input wire i_tx_en,
    input wire [3:0] i_txd,
    // Receive datapath
    input wire i_rx_dv,
    input wire [3:0] i_rxd,
    output reg o_rx_dv,
    output reg [3:0] o_rxd,
    // Controls to the 10 Mb/s path
    output wire [2:0] o_squelch_on_level,
    output wire o_normal_link_pulse_en,
    output wire o_link_good_10,
    output wire o_phy_status_polarity,
    output wire o_collision_test_en,
    output wire o_tx_runaway_guard_en,
    output wire o_selftest_continuous,
    output wire o_driver_pattern_active,
    output wire [1:0] o_driver_pattern_select,
    output reg o_pattern_seq_start
);

    localparam [1:0] PAT_DATA_V0 = 2'h0;
    localparam [1:0] PAT_DATA_V1 = 2'h1;
    localparam [1:0] PAT_LINK_PULSE = 2'h2;
    localparam [1:0] PAT_MANCH_ONES = 2'h3;
    localparam [15:0] GAP_SHORT = GAP_SHORT_CYC[15:0];
    localparam [15:0] GAP_LONG = GAP_LONG_CYC[15:0];

    // Address match against one register offset
    function reg_match;
        input [4:0] addr;
        input [4:0] target;
        begin
            reg_match = (addr == target);
        end
    endfunction

    // Stored value of a write; masked bits are never kept
    function [15:0] masked_write;
        input [15:0] wdata;
        input [15:0] wmask;
        begin
            masked_write = wdata & wmask;
        end
    endfunction

    // Counter step that sticks at all ones instead of wrapping
    function [7:0] sat_inc8;
        input [7:0] value;
        begin
            if (value == 8'hff) begin
                sat_inc8 = value;
            end else begin
                sat_inc8 = value + 8'h01;
            end
        end
    endfunction

    // Reload is one less, as the start cycle counts as part of the gap
    function [15:0] gap_reload;
        input long_gap;
        begin
            if (long_gap) begin
                gap_reload = GAP_LONG - 16'h0001;
            end else begin
                gap_reload = GAP_SHORT - 16'h0001;
            end
        end
    endfunction

    // Steady tone runs without gaps, so only three selects are timed
    function is_gapped_pattern;
        input [1:0] sel;
        begin
            case (sel)
                PAT_DATA_V0: is_gapped_pattern = 1'b1;
                PAT_DATA_V1: is_gapped_pattern = 1'b1;
                PAT_LINK_PULSE: is_gapped_pattern = 1'b1;
                PAT_MANCH_ONES: is_gapped_pattern = 1'b0;
                default: is_gapped_pattern = 1'b0;
            endcase
        end
    endfunction

    // Stored fields and counters
    reg [15:0] sc_q;
    reg [15:0] ext_q;
    reg pol_q;
    reg [7:0] err_cnt_q;
    reg [7:0] err_cnt_d;
    reg inject_prev_q;
    reg inject_q;
    reg [15:0] gap_cnt_q;
    reg [15:0] gap_cnt_d;
    reg seq_start_d;
    reg echo_dv_d;
    reg [3:0] echo_rxd_d;

    // Decoded strobes and modes
    wire sc_hit = reg_match(i_reg_addr, `TBT_SC_ADDR);
    wire ext_hit = reg_match(i_reg_addr, `TBT_EXT_ADDR);
    wire sc_wr = i_reg_wr && sc_hit;
    wire ext_wr = i_reg_wr && ext_hit;
    wire sc_rd = i_reg_rd && sc_hit;
    wire pat_en = ext_q[`TBT_EXT_PAT_EN];
    wire [1:0] pat_sel = ext_q[`TBT_EXT_PAT_HI:`TBT_EXT_PAT_LO];
    wire half_10 = i_speed_10 && !i_full_duplex;
    wire echo_on = half_10 && !sc_q[`TBT_SC_ECHO_DIS];
    wire count_err = i_selftest_nibble_err || inject_q;

    assign o_reg_hit = sc_hit || ext_hit;

    // Status/control register; reserved bits are plain storage
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sc_q <= `TBT_SC_RESET;
        end else if (sc_wr) begin
            sc_q <= masked_write(i_reg_wdata, `TBT_SC_WMASK);
        end
    end

    // Extension register; the counter field lives elsewhere
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ext_q <= `TBT_EXT_RESET;
        end else if (ext_wr) begin
            ext_q <= masked_write(i_reg_wdata, `TBT_EXT_WMASK);
        end
    end

    // Latched-high polarity; a new event in the reading cycle survives
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pol_q <= 1'b0;
        end else if (i_pol_inverted_evt) begin
            pol_q <= 1'b1;
        end else if (sc_rd) begin
            pol_q <= 1'b0;
        end
    end

    // Phy status reads leave the flag alone
    assign o_phy_status_polarity = pol_q;

    // Edge detect, so a force-error bit held high still counts once
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            inject_prev_q <= 1'b0;
            inject_q <= 1'b0;
        end else begin
            inject_prev_q <= i_selftest_inject_error;
            inject_q <= i_selftest_inject_error && !inject_prev_q;
        end
    end

    // Restart has priority over a same-cycle error
    always @* begin
        err_cnt_d = err_cnt_q;
        if (i_selftest_start) begin
            err_cnt_d = 8'h00;
        end else if (count_err) begin
            err_cnt_d = sat_inc8(err_cnt_q);
        end
    end

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            err_cnt_q <= 8'h00;
        end else begin
            err_cnt_q <= err_cnt_d;
        end
    end

    // Read mux; the read strobe only matters for the flag clear
    always @* begin
        o_reg_rdata = 16'h0000;
        if (sc_hit) begin
            o_reg_rdata = sc_q;
            o_reg_rdata[`TBT_SC_POLARITY] = pol_q;
        end else if (ext_hit) begin
            o_reg_rdata = ext_q;
            o_reg_rdata[`TBT_EXT_ERR_HI:`TBT_EXT_ERR_LO] = err_cnt_q;
        end
    end

    // Half-duplex echo; basic-mode loopback bypasses the disable
    always @* begin
        echo_dv_d = i_rx_dv;
        echo_rxd_d = i_rxd;
        if (i_basic_loopback) begin
            echo_dv_d = i_tx_en;
            echo_rxd_d = i_txd;
        end else if (echo_on && i_tx_en) begin
            echo_dv_d = 1'b1;
            echo_rxd_d = i_txd;
        end
    end

    // One cycle of latency on every receive path, echoed or not
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_dv <= 1'b0;
            o_rxd <= 4'h0;
        end else begin
            o_rx_dv <= echo_dv_d;
            o_rxd <= echo_rxd_d;
        end
    end

    assign o_squelch_on_level = sc_q[`TBT_SC_SQUELCH_HI:`TBT_SC_SQUELCH_LO];
    assign o_normal_link_pulse_en = !sc_q[`TBT_SC_LINK_PULSE_TX_DISABLE];
    assign o_link_good_10 = sc_q[`TBT_SC_FORCE_LINK] || i_link_pulse_good;
    // Heartbeat only ever runs in half-duplex 10 Mb/s
    assign o_collision_test_en = half_10 && !sc_q[`TBT_SC_COLL_TEST_DIS];
    // Guard is meaningless outside 10 Mb/s, so it is held off there
    assign o_tx_runaway_guard_en = i_speed_10 && !sc_q[`TBT_SC_GUARD_DIS];
    assign o_selftest_continuous = ext_q[`TBT_EXT_CONT];
    assign o_driver_pattern_active = pat_en;
    assign o_driver_pattern_select = pat_sel;

    // Gap timer between repeated data or link-pulse sequences
    always @* begin
        gap_cnt_d = 16'h0000;
        seq_start_d = 1'b0;
        if (pat_en && is_gapped_pattern(pat_sel)) begin
            if (gap_cnt_q == 16'h0000) begin
                seq_start_d = 1'b1;
                gap_cnt_d = gap_reload(ext_q[`TBT_EXT_GAP_SEL]);
            end else begin
                gap_cnt_d = gap_cnt_q - 16'h0001;
            end
        end
    end

    // Start pulse is registered so the driver sees no glitches
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gap_cnt_q <= 16'h0000;
            o_pattern_seq_start <= 1'b0;
        end else begin
            gap_cnt_q <= gap_cnt_d;
            o_pattern_seq_start <= seq_start_d;
        end
    end

endmodule // tenbase_t_control_and_bist_ext

/* verification/tenbase_t_ctrl_assertions.sv */
// Checker on the ports of the 10 Mb/s control block.
// Bound to the block; one clock, async active-low reset.
`timescale 1ns/1ps
module tenbase_t_ctrl_checker #(
    parameter GAP_SHORT_CYC = 10,
    parameter GAP_LONG_CYC = 15
) (
    // Watched ports
    input wire i_core_clk, i_rst_n, i_reg_wr, i_reg_rd, i_speed_10, i_full_duplex,
    input wire i_basic_loopback, i_pol_inverted_evt, i_tx_en, o_rx_dv, o_normal_link_pulse_en,
    input wire o_link_good_10, o_phy_status_polarity, o_collision_test_en,
    input wire o_tx_runaway_guard_en, o_driver_pattern_active, o_pattern_seq_start,
    input wire [4:0] i_reg_addr,
    input wire [15:0] i_reg_wdata,
    input wire [3:0] i_txd, o_rxd,
    input wire [2:0] o_squelch_on_level,
    input wire [1:0] o_driver_pattern_select
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    wire sc_wr = i_reg_wr && i_reg_addr == 5'h1a;
    wire ext_wr = i_reg_wr && i_reg_addr == 5'h1b;
    // Pattern armed from idle, select not the steady tone
    sequence pat_arm;
        ext_wr && i_reg_wdata[4] && i_reg_wdata[1:0] != 2'b11 && !o_driver_pattern_active
        ##1 o_driver_pattern_active;
    endsequence
    squelch_write_a: assert property (sc_wr |=> o_squelch_on_level == $past(i_reg_wdata[11:9]))
        else $error("squelch field");
    pulse_disable_a: assert property (sc_wr |=> o_normal_link_pulse_en != $past(i_reg_wdata[7]))
        else $error("link pulse enable");
    force_link_a: assert property (sc_wr && i_reg_wdata[6] |=> o_link_good_10)
        else $error("forced link");
    heartbeat_off_a: assert property (!i_speed_10 || i_full_duplex |-> !o_collision_test_en)
        else $error("heartbeat");
    guard_fast_a: assert property (!i_speed_10 |-> !o_tx_runaway_guard_en)
        else $error("jabber guard");
    basic_loop_a: assert property (i_basic_loopback && i_tx_en |=> o_rx_dv && o_rxd == $past(i_txd))
        else $error("loopback");
    pol_set_a: assert property (i_pol_inverted_evt |=> o_phy_status_polarity)
        else $error("polarity set");
    pol_clear_a: assert property (i_reg_rd && i_reg_addr == 5'h1a && !i_pol_inverted_evt
        |=> !o_phy_status_polarity) else $error("polarity clear");
    pattern_start_a: assert property (pat_arm |=> o_pattern_seq_start)
        else $error("pattern start");
    pattern_sel_a: assert property (ext_wr |=> o_driver_pattern_select == $past(i_reg_wdata[1:0]))
        else $error("pattern select");
endmodule // tenbase_t_ctrl_checker

/* verification/mgmt_station.sv */
// Station management model: register writes and reads.
// Strobes move 1 ns after the rising edge; data sampled on the edge.
`timescale 1ns/1ps
module mgmt_station (
    // Clock and read data
    input wire i_core_clk,
    input wire [15:0] i_rdata,
    // Access strobes
    output logic [4:0] o_addr = 5'h00,
    output logic o_wr = 1'b0,
    output logic o_rd = 1'b0,
    output logic [15:0] o_wdata = 16'h0000
);
    logic [15:0] sc_shadow = 16'h0804;
    task automatic access(input logic [4:0] a, input logic [15:0] d, input logic w,
                          output logic [15:0] q);
        @(posedge i_core_clk) #1;
        o_addr = a;
        o_wdata = d;
        o_wr = w;
        o_rd = !w;
        @(posedge i_core_clk);
        q = i_rdata;
        #1 o_wr = 1'b0;
        o_rd = 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] q;
        if (a == 5'h1a) d = (d & 16'h0fc3) | 16'h0004;
        if (a == 5'h1b) d = d & 16'hff37;
        // Continuous transmit would be cut off by the guard
        if (a == 5'h1b && d[5] && !sc_shadow[0]) begin
            sc_shadow[0] = 1'b1;
            access(5'h1a, sc_shadow, 1'b1, q);
        end
        if (a == 5'h1a) sc_shadow = d;
        access(a, d, 1'b1, q);
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] q);
        access(a, 16'h0000, 1'b0, q);
    endtask
endmodule // mgmt_station

/* verification/tenbase_t_control_and_bist_ext_tb_top.sv */
// Bench for the 10 Mb/s control block, driven by the management model.
// 125 MHz clock; short gap counts so the pattern timing is measurable.
`timescale 1ns/1ps
module tenbase_t_control_and_bist_ext_tb_top;
    logic i_core_clk = 0, i_rst_n = 0, i_speed_10 = 1, i_full_duplex = 0, i_basic_loopback = 0;
    logic i_pol_inverted_evt = 0, i_phy_status_rd = 0, i_link_pulse_good = 0, i_tx_en = 0;
    logic i_selftest_start = 0, i_selftest_nibble_err = 0, i_selftest_inject_error = 0;
    logic i_rx_dv = 0, i_reg_wr, i_reg_rd;
    logic [3:0] i_txd = 4'ha, i_rxd = 4'h5, o_rxd;
    logic [4:0] i_reg_addr;
    logic [15:0] i_reg_wdata, o_reg_rdata, q;
    logic [2:0] o_squelch_on_level;
    logic [1:0] o_driver_pattern_select;
    logic o_reg_hit, o_rx_dv, o_normal_link_pulse_en, o_link_good_10, o_phy_status_polarity;
    logic o_collision_test_en, o_tx_runaway_guard_en, o_selftest_continuous;
    logic o_driver_pattern_active, o_pattern_seq_start;
    int err_count = 0, num_checks = 0, n, k;
    tenbase_t_control_and_bist_ext #(.GAP_SHORT_CYC(10), .GAP_LONG_CYC(15))
        tenbase_t_control_and_bist_ext_inst (.*);
    mgmt_station mgmt_station_inst (.i_core_clk, .i_rdata(o_reg_rdata), .o_addr(i_reg_addr),
        .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_wdata(i_reg_wdata));
    initial forever #4 i_core_clk = ~i_core_clk;
    task automatic chk(string s, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cyc(int c);
        repeat (c) @(posedge i_core_clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        cyc(1);
        s = 0;
    endtask
    // Bounded wait for a sequence start, k counts idle cycles
    task automatic wait_seq;
        for (k = 0; k < 100 && o_pattern_seq_start !== 1'b1; k++) cyc(1);
        if (k == 100) begin
            err_count++;
            test_done;
        end
        cyc(1);
    endtask
    task automatic gap(int e);
        wait_seq;
        wait_seq;
        chk("gap", 16'(k + 1), 16'(e));
    endtask
    initial begin
        cyc(10);
        i_rst_n = 1;
        mgmt_station_inst.rd(5'h1a, q);
        chk("sc reset", q, 16'h0804);
        mgmt_station_inst.rd(5'h1b, q);
        chk("ext reset", q, 16'h0000);
        mgmt_station_inst.rd(5'h1c, q);
        chk("unmapped", {o_reg_hit, q[14:0]}, 16'h0000);
        mgmt_station_inst.wr(5'h1a, 16'h0bc7);
        mgmt_station_inst.rd(5'h1a, q);
        chk("sc write", q, 16'h0bc7);
        chk("squelch", o_squelch_on_level, 16'h0005);
        chk("pulses", {o_normal_link_pulse_en, o_link_good_10}, 16'h0001);
        chk("disables", {o_collision_test_en, o_tx_runaway_guard_en}, 16'h0000);
        i_tx_en = 1;
        cyc(2);
        chk("no echo", o_rx_dv, 16'h0000);
        i_basic_loopback = 1;
        cyc(2);
        chk("loopback", {o_rx_dv, o_rxd}, 16'h001a);
        i_basic_loopback = 0;
        mgmt_station_inst.wr(5'h1a, 16'h0800);
        cyc(1);
        chk("echo", {o_rx_dv, o_rxd}, 16'h001a);
        chk("enables", {o_normal_link_pulse_en, o_link_good_10}, 16'h0002);
        chk("hb guard", {o_collision_test_en, o_tx_runaway_guard_en}, 16'h0003);
        i_full_duplex = 1;
        cyc(2);
        chk("full duplex", {o_rx_dv, o_collision_test_en}, 16'h0000);
        i_speed_10 = 0;
        cyc(1);
        chk("fast guard", o_tx_runaway_guard_en, 16'h0000);
        i_tx_en = 0;
        i_speed_10 = 1;
        i_full_duplex = 0;
        pulse(i_pol_inverted_evt);
        pulse(i_phy_status_rd);
        mgmt_station_inst.rd(5'h1a, q);
        chk("pol set", q, 16'h0814);
        mgmt_station_inst.rd(5'h1a, q);
        chk("pol clear", q, 16'h0804);
        pulse(i_selftest_start);
        for (n = 0; n < 3; n++) pulse(i_selftest_nibble_err);
        pulse(i_selftest_inject_error);
        cyc(2);
        mgmt_station_inst.rd(5'h1b, q);
        chk("err count", q, 16'h0400);
        i_selftest_nibble_err = 1;
        cyc(300);
        i_selftest_nibble_err = 0;
        mgmt_station_inst.wr(5'h1b, 16'h0100);
        mgmt_station_inst.rd(5'h1b, q);
        chk("saturate", q, 16'hff00);
        pulse(i_selftest_start);
        mgmt_station_inst.rd(5'h1b, q);
        chk("restart", q, 16'h0000);
        mgmt_station_inst.wr(5'h1b, 16'h0010);
        gap(10);
        mgmt_station_inst.wr(5'h1b, 16'h0014);
        gap(15);
        for (n = 0; n < 4; n++) begin
            mgmt_station_inst.wr(5'h1b, 16'(16'h0010 + n));
            chk("select", o_driver_pattern_select, 16'(n));
        end
        mgmt_station_inst.wr(5'h1b, 16'h0020);
        chk("continuous", {o_selftest_continuous, o_tx_runaway_guard_en}, 16'h0002);
        test_done;
    end
endmodule // tenbase_t_control_and_bist_ext_tb_top
bind tenbase_t_control_and_bist_ext tenbase_t_ctrl_checker #(.GAP_SHORT_CYC(GAP_SHORT_CYC),
    .GAP_LONG_CYC(GAP_LONG_CYC)) tenbase_t_ctrl_checker_inst (.*);
